// ### src/dqc_device.sv
// Converter end: command decode, holding and output registers, load strobe
`timescale 1ns/1ps
module dqc_device
(
   // Link from the bus receiver
   dqc_link_if.device link,
   // Reset, synchronous active low
   input wire logic I_RST_B,
   // Address straps and load strobe
   input wire logic [1:0] I_EXT_ADDR,
   input wire logic I_LOAD_STROBE,
   // Channel registers, channel A in the low bits
   output logic [dqc_pkg::NUM_CH*dqc_pkg::CH_W-1:0] O_CHAN_OUT,
   output logic [dqc_pkg::NUM_CH*dqc_pkg::CH_W-1:0] O_CHAN_HOLD
);
   import dqc_pkg::*;

   typedef enum logic [1:0]
   {
      DQC_EXP_CMD = 2'b00,
      DQC_EXP_HI = 2'b01,
      DQC_EXP_LO = 2'b10
   } dqc_byte_t;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic rst_b_meta_reg;
   logic rst_b_reg;
   logic [10:0] link_meta_reg;
   logic [10:0] link_sync_reg;
   logic [1:0] ext_meta_reg;
   logic [1:0] ext_sync_reg;
   logic load_meta_reg;
   logic load_sync_reg;
   logic load_prev_reg;

   // Two flops for every input from outside this clock
   always_ff @(posedge link.link_clk)
   begin
      rst_b_meta_reg <= I_RST_B;
      rst_b_reg <= rst_b_meta_reg;
      link_meta_reg <= {link.frame, link.byte_stb, link.ack_fall, link.byte_data};
      link_sync_reg <= link_meta_reg;
      ext_meta_reg <= I_EXT_ADDR;
      ext_sync_reg <= ext_meta_reg;
      load_meta_reg <= I_LOAD_STROBE;
      load_sync_reg <= load_meta_reg;
   end

   // Named views of the synchronised link
   wire frame_s = link_sync_reg[10];
   wire stb_s = link_sync_reg[9];
   wire ack_s = link_sync_reg[8];
   wire [7:0] data_s = link_sync_reg[7:0];

   // ****************************************
   // Byte sequencing
   // ****************************************
   dqc_byte_t state_reg;
   dqc_byte_t state_next;
   logic [7:0] cmd_reg;
   logic [7:0] cmd_next;
   logic [7:0] hi_reg;
   logic [7:0] hi_next;
   logic [7:0] lo_reg;
   logic [7:0] lo_next;
   logic pend_reg;
   logic pend_next;

   // Command once per frame, then high/low pairs until frame ends
   always_comb
   begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      hi_next = hi_reg;
      lo_next = lo_reg;
      pend_next = pend_reg;
      if (!frame_s)
      begin
         state_next = DQC_EXP_CMD;
         pend_next = 1'b0;
      end
      else if (stb_s)
      begin
         case (state_reg)
            DQC_EXP_CMD:
            begin
               cmd_next = data_s;
               state_next = DQC_EXP_HI;
            end
            DQC_EXP_HI:
            begin
               hi_next = data_s;
               state_next = DQC_EXP_LO;
            end
            DQC_EXP_LO:
            begin
               lo_next = data_s;
               pend_next = 1'b1;
               state_next = DQC_EXP_HI;
            end
            default:
            begin
               state_next = DQC_EXP_CMD;
            end
         endcase
      end
      else if (ack_s && pend_reg)
      begin
         pend_next = 1'b0;
      end
   end

   // Sequencer state
   always_ff @(posedge link.link_clk)
   begin
      if (!rst_b_reg)
      begin
         state_reg <= DQC_EXP_CMD;
         cmd_reg <= BYTE_RESET;
         hi_reg <= BYTE_RESET;
         lo_reg <= BYTE_RESET;
         pend_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
         pend_reg <= pend_next;
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   // Fields of the stored command
   wire dqc_load_t load_mode = dqc_load_t'(cmd_reg[CMD_LOAD_HI:CMD_LOAD_LO]);
   wire [1:0] chan_pick = cmd_reg[CMD_CH_HI:CMD_CH_LO];
   wire power_down_flag = cmd_reg[CMD_PD];
   wire bcast_data = cmd_reg[CMD_BCAST_DATA];
   wire addr_match = (cmd_reg[CMD_EXT_HI:CMD_EXT_LO] == ext_sync_reg);
   // Update moment: ack that follows the low byte
   wire apply = frame_s && ack_s && pend_reg && !stb_s;
   // Word for the targeted registers, code over data
   wire [11:0] data_word = {PD_NORMAL, hi_reg, lo_reg[LO_DATA_HI:LO_DATA_LO]};
   wire [11:0] pd_word = {hi_reg[PD_CODE_HI:PD_CODE_LO], DATA_ZERO};
   wire [11:0] new_word = power_down_flag ? pd_word : data_word;
   // Load strobe rising edge
   wire load_rise = load_sync_reg && !load_prev_reg;

   // ****************************************
   // Holding and output registers
   // ****************************************
   logic [NUM_CH-1:0][CH_W-1:0] hold_reg;
   logic [NUM_CH-1:0][CH_W-1:0] hold_next;
   logic [NUM_CH-1:0][CH_W-1:0] out_reg;
   logic [NUM_CH-1:0][CH_W-1:0] out_next;

   // Next values; serial command beats a coincident strobe on the outputs that it writes
   always_comb
   begin
      hold_next = hold_reg;
      out_next = out_reg;
      if (load_rise)
      begin
         out_next = hold_reg;
      end
      if (apply)
      begin
         case (load_mode)
            DQC_LOAD_HOLD:
            begin
               if (addr_match)
               begin
                  hold_next[chan_pick] = new_word;
               end
            end
            DQC_LOAD_ONE:
            begin
               if (addr_match)
               begin
                  hold_next[chan_pick] = new_word;
                  out_next[chan_pick] = new_word;
               end
            end
            DQC_LOAD_ALL:
            begin
               if (addr_match)
               begin
                  hold_next[chan_pick] = new_word;
                  out_next = hold_reg;
                  out_next[chan_pick] = new_word;
               end
            end
            DQC_LOAD_BCAST:
            begin
               if (bcast_data)
               begin
                  for (int i = 0; i < NUM_CH; i++)
                  begin
                     hold_next[i] = new_word;
                     out_next[i] = new_word;
                  end
               end
               else
               begin
                  out_next = hold_reg;
               end
            end
            default:
            begin
               out_next = out_reg;
            end
         endcase
      end
   end

   // Channel registers, cleared by reset
   always_ff @(posedge link.link_clk)
   begin
      if (!rst_b_reg)
      begin
         hold_reg <= {NUM_CH{CH_RESET}};
         out_reg <= {NUM_CH{CH_RESET}};
         load_prev_reg <= 1'b0;
      end
      else
      begin
         hold_reg <= hold_next;
         out_reg <= out_next;
         load_prev_reg <= load_sync_reg;
      end
   end

   // Outputs straight from the channel flops
   assign O_CHAN_OUT = out_reg;
   assign O_CHAN_HOLD = hold_reg;
endmodule

// ### src/dqc_pkg.sv
// Shared constants and types for the quad converter command and update logic
package dqc_pkg;
   // ****************************************
   // Widths and counts
   // ****************************************
   localparam int NUM_CH = 4;
   localparam int CH_W = 12;
   localparam int DATA_W = 10;
   localparam int BYTE_W = 8;
   localparam int SEL_W = 2;
   // Command byte field positions
   localparam int CMD_EXT_HI = 7;
   localparam int CMD_EXT_LO = 6;
   localparam int CMD_LOAD_HI = 5;
   localparam int CMD_LOAD_LO = 4;
   localparam int CMD_BCAST_DATA = 2;
   localparam int CMD_CH_HI = 2;
   localparam int CMD_CH_LO = 1;
   localparam int CMD_PD = 0;
   // Data byte field positions
   localparam int PD_CODE_HI = 7;
   localparam int PD_CODE_LO = 6;
   localparam int LO_DATA_HI = 7;
   localparam int LO_DATA_LO = 6;
   // Reset values and fixed channel word fields
   localparam logic [11:0] CH_RESET = 12'h000;
   localparam logic [9:0] DATA_ZERO = 10'h000;
   localparam logic [1:0] PD_NORMAL = 2'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Load modes of the command byte
   typedef enum logic [1:0]
   {
      DQC_LOAD_HOLD = 2'b00,
      DQC_LOAD_ONE = 2'b01,
      DQC_LOAD_ALL = 2'b10,
      DQC_LOAD_BCAST = 2'b11
   } dqc_load_t;
   // ****************************************
   // Controller register map (byte offsets)
   // ****************************************
   localparam int WB_ADR_W = 4;
   localparam logic [3:0] REG_CMD_OFS = 4'h0;
   localparam logic [3:0] REG_DATA_OFS = 4'h4;
   localparam logic [3:0] REG_CTRL_OFS = 4'h8;
   localparam logic [3:0] REG_STAT_OFS = 4'hC;
   localparam int CTRL_SEND_BIT = 0;
   localparam int CTRL_KEEP_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OPEN_BIT = 1;
   // Reference cycles per half period of the link clock
   localparam int LINK_HALF_DIV = 2;
endpackage

// ### src/dqc_link_if.sv
// Received-byte link between the bus receiver side and the converter logic
`timescale 1ns/1ps
interface dqc_link_if;
   logic link_clk;
   logic frame;
   logic byte_stb;
   logic [7:0] byte_data;
   logic ack_fall;
   modport device (input link_clk, input frame, input byte_stb, input byte_data, input ack_fall);
   modport host (output link_clk, output frame, output byte_stb, output byte_data, output ack_fall);
endinterface

// ### src/dqc_host.sv
// Controller end: Wishbone registers, link clock divider and byte sender
`timescale 1ns/1ps
module dqc_host
(
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   // Wishbone slave
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [dqc_pkg::WB_ADR_W-1:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   // Link to the converter
   dqc_link_if.host link
);
   import dqc_pkg::*;

   typedef enum logic [2:0]
   {
      DQC_S_IDLE = 3'b000,
      DQC_S_CMD = 3'b001,
      DQC_S_CACK = 3'b010,
      DQC_S_HI = 3'b011,
      DQC_S_HACK = 3'b100,
      DQC_S_LO = 3'b101,
      DQC_S_LACK = 3'b110
   } dqc_send_t;

   // ****************************************
   // Wishbone register file
   // ****************************************
   logic ack_reg;
   logic [31:0] rdat_reg;
   logic [7:0] cmd_reg;
   logic [7:0] hi_reg;
   logic [7:0] lo_reg;
   logic go_reg;
   logic keep_reg;
   logic open_reg;

   // Decode; a write lands on the acked edge
   wire req = I_WB_CYC && I_WB_STB;
   wire wr = req && I_WB_WE && ack_reg;
   wire wr_cmd = wr && (I_WB_ADR == REG_CMD_OFS) && I_WB_SEL[0];
   wire wr_data = wr && (I_WB_ADR == REG_DATA_OFS);
   wire wr_ctrl = wr && (I_WB_ADR == REG_CTRL_OFS) && I_WB_SEL[0] && !go_reg;
   wire [31:0] rd_mux = (I_WB_ADR == REG_CMD_OFS) ? {24'h000000, cmd_reg} :
                        (I_WB_ADR == REG_DATA_OFS) ? {16'h0000, lo_reg, hi_reg} :
                        (I_WB_ADR == REG_STAT_OFS) ? {30'h0, open_reg, go_reg} : 32'h00000000;

   // ****************************************
   // Link clock divider
   // ****************************************
   logic [7:0] div_reg;
   logic lclk_reg;
   wire half_end = (div_reg == 8'(LINK_HALF_DIV - 1));
   wire tick = half_end && lclk_reg;

   // Free-running divider; link outputs change as link clock falls
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_B)
      begin
         div_reg <= 8'h00;
         lclk_reg <= 1'b0;
      end
      else
      begin
         div_reg <= half_end ? 8'h00 : div_reg + 8'h01;
         lclk_reg <= half_end ? !lclk_reg : lclk_reg;
      end
   end

   // Bus answer one cycle after request, dropped the next
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_B)
      begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
         cmd_reg <= BYTE_RESET;
         hi_reg <= BYTE_RESET;
         lo_reg <= BYTE_RESET;
      end
      else
      begin
         ack_reg <= req && !ack_reg;
         rdat_reg <= rd_mux;
         cmd_reg <= wr_cmd ? I_WB_DAT[7:0] : cmd_reg;
         hi_reg <= (wr_data && I_WB_SEL[0]) ? I_WB_DAT[7:0] : hi_reg;
         lo_reg <= (wr_data && I_WB_SEL[1]) ? I_WB_DAT[15:8] : lo_reg;
      end
   end

   // ****************************************
   // Byte sender
   // ****************************************
   dqc_send_t st_reg;
   logic frame_reg;
   logic stb_reg;
   logic ackf_reg;
   logic [7:0] byte_reg;

   // Each step holds for one whole link clock period
   always_ff @(posedge I_REF_CLK)
   begin
      if (!I_RST_B)
      begin
         st_reg <= DQC_S_IDLE;
         go_reg <= 1'b0;
         keep_reg <= 1'b0;
         open_reg <= 1'b0;
         frame_reg <= 1'b0;
         stb_reg <= 1'b0;
         ackf_reg <= 1'b0;
         byte_reg <= BYTE_RESET;
      end
      else if (wr_ctrl)
      begin
         go_reg <= I_WB_DAT[CTRL_SEND_BIT];
         keep_reg <= I_WB_DAT[CTRL_KEEP_BIT];
         if (!I_WB_DAT[CTRL_SEND_BIT] && !I_WB_DAT[CTRL_KEEP_BIT])
         begin
            open_reg <= 1'b0;
         end
      end
      else if (tick)
      begin
         stb_reg <= 1'b0;
         ackf_reg <= 1'b0;
         case (st_reg)
            DQC_S_IDLE:
            begin
               frame_reg <= go_reg || open_reg;
               if (go_reg)
               begin
                  stb_reg <= 1'b1;
                  byte_reg <= open_reg ? hi_reg : cmd_reg;
                  st_reg <= open_reg ? DQC_S_HI : DQC_S_CMD;
               end
            end
            DQC_S_CMD:
            begin
               ackf_reg <= 1'b1;
               st_reg <= DQC_S_CACK;
            end
            DQC_S_CACK:
            begin
               stb_reg <= 1'b1;
               byte_reg <= hi_reg;
               st_reg <= DQC_S_HI;
            end
            DQC_S_HI:
            begin
               ackf_reg <= 1'b1;
               st_reg <= DQC_S_HACK;
            end
            DQC_S_HACK:
            begin
               stb_reg <= 1'b1;
               byte_reg <= lo_reg;
               st_reg <= DQC_S_LO;
            end
            DQC_S_LO:
            begin
               ackf_reg <= 1'b1;
               st_reg <= DQC_S_LACK;
            end
            DQC_S_LACK:
            begin
               go_reg <= 1'b0;
               open_reg <= keep_reg;
               frame_reg <= keep_reg;
               st_reg <= DQC_S_IDLE;
            end
            default:
            begin
               st_reg <= DQC_S_IDLE;
            end
         endcase
      end
   end

   // Outputs from flops
   assign O_WB_ACK = ack_reg;
   assign O_WB_DAT = rdat_reg;
   assign link.link_clk = lclk_reg;
   assign link.frame = frame_reg;
   assign link.byte_stb = stb_reg;
   assign link.byte_data = byte_reg;
   assign link.ack_fall = ackf_reg;
endmodule

// ### bench/dqc_link_sva.sv
// Assertions on the received-byte link between controller and converter
`timescale 1ns/1ps
module dqc_link_sva
(
   // Link clock and controller reset
   input wire logic link_clk,
   input wire logic I_RST_B,
   // Link signals
   input wire logic frame,
   input wire logic byte_stb,
   input wire logic [7:0] byte_data,
   input wire logic ack_fall
);
   // ****
   // Bytes seen in the open frame
   // ****
   logic [7:0] byte_cnt_reg;
   logic [7:0] byte_cnt_next;
   default clocking cb @(posedge link_clk);
   endclocking
   // Low at the first link edge after reset, before any past value exists
   logic armed_reg = 1'b0;
   default disable iff (!I_RST_B || !armed_reg);
   // Count restarts whenever the frame is closed
   assign byte_cnt_next = !frame ? 8'h00 : (byte_stb ? byte_cnt_reg + 8'h01 : byte_cnt_reg);
   // Counter register
   always_ff @(posedge link_clk)
   begin
      armed_reg <= I_RST_B;
      if (!I_RST_B)
         byte_cnt_reg <= 8'h00;
      else
         byte_cnt_reg <= byte_cnt_next;
   end
   // ****
   // Link protocol
   // ****
   chk_stb_pulse: assert property (byte_stb |=> !byte_stb)
      else $error("byte strobe longer than one link cycle");
   chk_ack_follows: assert property (byte_stb |=> ack_fall)
      else $error("no acknowledge after byte");
   chk_ack_cause: assert property (ack_fall |-> $past(byte_stb))
      else $error("acknowledge without byte");
   chk_ack_pulse: assert property (ack_fall |=> !ack_fall)
      else $error("acknowledge longer than one link cycle");
   chk_stb_framed: assert property (byte_stb |-> frame)
      else $error("byte outside frame");
   chk_ack_framed: assert property (ack_fall |-> frame)
      else $error("acknowledge outside frame");
   chk_frame_cmd: assert property ($rose(frame) |-> byte_stb)
      else $error("frame opened without command byte");
   chk_frame_pairs: assert property ($fell(frame) |-> byte_cnt_reg[0] && byte_cnt_reg >= 8'h03)
      else $error("frame closed without whole byte pairs");
   // Main scenarios
   cover property ($rose(frame));
   cover property ($fell(frame) && byte_cnt_reg > 8'h03);
   cover property ($rose(frame) && byte_data[5:4] == 2'b11);
endmodule

// ### bench/tb_top.sv
// Testbench joining controller and converter ends over the link
`timescale 1ns/1ps
module tb_top;
   import dqc_pkg::*;
   // ****
   // Stimulus and observation
   // ****
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic dev_rst_b = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic [1:0] ext_addr = 2'h2;
   logic load_strobe = 1'b0;
   logic [47:0] chan_out;
   logic [47:0] chan_hold;
   logic [31:0] rd;
   logic [11:0] exp_hold [NUM_CH];
   logic [11:0] exp_out [NUM_CH];
   int errors = 0;
   int check_count = 0;
   int cycle_cnt = 0;
   dqc_link_if link_i();
   // Controller end
   dqc_host dqc_host_i (.I_REF_CLK(ref_clk), .I_RST_B(rst_b), .I_WB_CYC(wb_cyc), .I_WB_STB(wb_stb),
      .I_WB_WE(wb_we), .I_WB_ADR(wb_adr), .I_WB_SEL(wb_sel), .I_WB_DAT(wb_wdat), .O_WB_DAT(wb_rdat),
      .O_WB_ACK(wb_ack), .link(link_i.host));
   // Converter end
   dqc_device dqc_device_i (.link(link_i.device), .I_RST_B(dev_rst_b), .I_EXT_ADDR(ext_addr),
      .I_LOAD_STROBE(load_strobe), .O_CHAN_OUT(chan_out), .O_CHAN_HOLD(chan_hold));
   // Link checker
   dqc_link_sva dqc_link_sva_i (.link_clk(link_i.link_clk), .I_RST_B(rst_b), .frame(link_i.frame),
      .byte_stb(link_i.byte_stb), .byte_data(link_i.byte_data), .ack_fall(link_i.ack_fall));
   // Reference clock
   always #50 ref_clk = ~ref_clk;
   // Hang guard
   always @(posedge ref_clk)
   begin
      cycle_cnt++;
      if (cycle_cnt == 40000)
      begin
         errors++;
         end_sim();
      end
   end
   // ****
   // Tasks
   // ****
   task end_sim;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task wb_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= 1'b1;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= s;
      do @(posedge ref_clk); while (wb_ack !== 1'b1);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
   task wb_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= 1'b0;
      wb_adr <= a;
      wb_sel <= 4'hF;
      do @(posedge ref_clk); while (wb_ack !== 1'b1);
      d = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   // Expected effect of one byte pair
   task apply(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo);
      logic [11:0] w;
      int ch;
      w = cmd[CMD_PD] ? {hi[7:6], DATA_ZERO} : {PD_NORMAL, hi, lo[7:6]};
      ch = int'(cmd[2:1]);
      if (cmd[5:4] == 2'b11)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (cmd[CMD_BCAST_DATA])
               exp_hold[i] = w;
            exp_out[i] = exp_hold[i];
         end
      end
      else if (cmd[7:6] == ext_addr)
      begin
         exp_hold[ch] = w;
         if (cmd[5:4] == 2'b01)
            exp_out[ch] = w;
         for (int i = 0; i < NUM_CH; i++)
            if (cmd[5:4] == 2'b10)
               exp_out[i] = exp_hold[i];
      end
   endtask
   task clear_model;
      for (int i = 0; i < NUM_CH; i++)
      begin
         exp_hold[i] = CH_RESET;
         exp_out[i] = CH_RESET;
      end
   endtask
   task check_regs;
      logic [47:0] h;
      logic [47:0] o;
      for (int i = 0; i < NUM_CH; i++)
      begin
         h[i*CH_W +: CH_W] = exp_hold[i];
         o[i*CH_W +: CH_W] = exp_out[i];
      end
      chk(chan_hold, h);
      chk(chan_out, o);
   endtask
   // Command (when first), one pair, wait for the update to land
   task send_pair(input logic [7:0] cmd, input logic [7:0] hi, input logic [7:0] lo, input bit keep, input bit first);
      if (first)
         wb_write(REG_CMD_OFS, {24'h0, cmd}, 4'h1);
      wb_write(REG_DATA_OFS, {16'h0, lo, hi}, 4'h3);
      wb_write(REG_CTRL_OFS, {30'h0, keep, 1'b1}, 4'h1);
      do wb_read(REG_STAT_OFS, rd); while (rd[STAT_BUSY_BIT] !== 1'b0);
      repeat (5) @(posedge link_i.link_clk);
      @(posedge ref_clk);
      apply(cmd, hi, lo);
   endtask
   task test_done(input string name);
      $display("test %0s done", name);
   endtask
   // ****
   // Test sequence
   // ****
   initial
   begin
      clear_model();
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (24) @(posedge ref_clk);
      dev_rst_b <= 1'b1;
      repeat (16) @(posedge ref_clk);
      check_regs();
      wb_read(4'h2, rd);
      chk({16'h0, rd}, 48'h0);
      wb_write(REG_CMD_OFS, 32'h0000_00A5, 4'h1);
      wb_read(REG_CMD_OFS, rd);
      chk({16'h0, rd}, 48'h0000_0000_00A5);
      test_done("reset and registers");
      for (int c = 0; c < NUM_CH; c++)
      begin
         send_pair({2'h2, 2'b00, 1'b1, c[1:0], 1'b0}, {c[1:0], 6'h2B}, {~c[1:0], 6'h3F}, 1'b0, 1'b1);
         check_regs();
      end
      // Byte pair register holds the last pair, low byte above high byte
      wb_read(REG_DATA_OFS, rd);
      chk({16'h0, rd}, 48'h0000_0000_3FEB);
      send_pair({2'h2, 2'b00, 1'b0, 2'h1, 1'b1}, 8'h80, 8'h00, 1'b0, 1'b1);
      check_regs();
      test_done("hold only");
      send_pair({2'h2, 2'b01, 1'b0, 2'h2, 1'b0}, 8'hC3, 8'h80, 1'b0, 1'b1);
      check_regs();
      send_pair({2'h2, 2'b01, 1'b0, 2'h0, 1'b1}, 8'hC0, 8'h00, 1'b0, 1'b1);
      check_regs();
      send_pair({2'h1, 2'b01, 1'b0, 2'h3, 1'b0}, 8'hFF, 8'hC0, 1'b0, 1'b1);
      check_regs();
      send_pair({2'h2, 2'b10, 1'b0, 2'h3, 1'b0}, 8'h12, 8'h40, 1'b0, 1'b1);
      check_regs();
      test_done("load modes");
      send_pair({2'h2, 2'b01, 1'b0, 2'h1, 1'b0}, 8'h34, 8'hC0, 1'b1, 1'b1);
      check_regs();
      wb_read(REG_STAT_OFS, rd);
      chk({47'h0, rd[STAT_OPEN_BIT]}, 48'h1);
      send_pair({2'h2, 2'b01, 1'b0, 2'h1, 1'b0}, 8'h56, 8'h00, 1'b0, 1'b0);
      check_regs();
      test_done("repeated pairs");
      send_pair({2'h2, 2'b00, 1'b0, 2'h0, 1'b0}, 8'h77, 8'h40, 1'b0, 1'b1);
      send_pair({2'h2, 2'b00, 1'b0, 2'h2, 1'b0}, 8'h99, 8'hC0, 1'b0, 1'b1);
      check_regs();
      load_strobe <= 1'b1;
      repeat (16) @(posedge ref_clk);
      for (int i = 0; i < NUM_CH; i++)
         exp_out[i] = exp_hold[i];
      check_regs();
      load_strobe <= 1'b0;
      repeat (16) @(posedge ref_clk);
      test_done("load strobe");
      send_pair({2'h2, 2'b00, 1'b0, 2'h3, 1'b0}, 8'hE1, 8'h80, 1'b0, 1'b1);
      send_pair({2'h0, 2'b11, 1'b0, 2'h1, 1'b1}, 8'h00, 8'h00, 1'b0, 1'b1);
      check_regs();
      send_pair({2'h1, 2'b11, 1'b0, 2'h2, 1'b0}, 8'hAB, 8'h40, 1'b0, 1'b1);
      check_regs();
      send_pair({2'h3, 2'b11, 1'b0, 2'h2, 1'b1}, 8'h40, 8'h00, 1'b0, 1'b1);
      check_regs();
      test_done("broadcast");
      dev_rst_b <= 1'b0;
      repeat (24) @(posedge ref_clk);
      dev_rst_b <= 1'b1;
      repeat (16) @(posedge ref_clk);
      clear_model();
      check_regs();
      test_done("second reset");
      end_sim();
   end
endmodule
